// ==== rtl/wdt_pkg.sv ====
// Package of constants and types for the watchdog postscaled timer
package wdt_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int WDT_MCLK_HZ = 10_000_000;
   localparam int WDT_BASE_TICK_MS = 4;
   localparam int WDT_BASE_TICK_CYC = (WDT_MCLK_HZ / 1000) * WDT_BASE_TICK_MS;

   // ----------------------------------------------------------------
   // Postscaler layout
   // ----------------------------------------------------------------
   localparam int WDT_PS_WIDTH = 16;
   localparam int WDT_SEL_WIDTH = 4;
   localparam logic [WDT_SEL_WIDTH-1:0] WDT_SEL_RESET = 4'hF;
   localparam logic [2:0] WDT_FSEL_RESET = 3'h0;

   // ----------------------------------------------------------------
   // Grouped inputs and state type
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sleep_instr;
      logic clear_watchdog_instr;
      logic clock_fail;
   } wdt_clear_type;

   typedef enum logic [1:0] {
      WDT_OFF,
      WDT_RUN,
      WDT_FIRED
   } wdt_state_type;

endpackage

// ==== rtl/wdt_tick_div.sv ====
// Base tick divider producing a one-cycle enable pulse
`timescale 1ns/1ns
module wdt_tick_div
   import wdt_pkg::*;
#(
   parameter int DIV_CYC = WDT_BASE_TICK_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic run,
   output logic tick
);
   localparam int CW = $clog2(DIV_CYC);
   localparam logic [CW-1:0] LAST = CW'(DIV_CYC - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic at_last;
   logic tick_reg;

   assign at_last = (cnt_reg == LAST);
   assign cnt_next = (clr || !run || at_last) ? '0 : cnt_reg + 1'b1;
   assign tick = tick_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= run && !clr && at_last;
      end
   end
endmodule

// ==== rtl/wdt_top.sv ====
// Watchdog timer with base tick, 16-bit postscaler and period select
`timescale 1ns/1ns
// Functional notes
// - The watchdog runs from the low-frequency oscillator, switched on while it is enabled.
// - The base tick period is nominally 4 ms before postscaling.
// - The base tick drives a 16-bit postscaler, period is base times the ratio.
// - A configuration field picks which postscaler output sets the timeout.
// - Periods from 4 ms up to 131.072 s are selectable.
// - Sleep or clear-watchdog instructions clear the counter and postscaler.
// - A changed oscillator frequency select value clears both counts.
// - A reported clock failure clears both counts.
module wdt_top
   import wdt_pkg::*;
#(
   parameter int TICK_CYC = WDT_BASE_TICK_CYC,
   parameter int PS_WIDTH = WDT_PS_WIDTH
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wdt_enable,
   input wire logic [WDT_SEL_WIDTH-1:0] period_select,
   input wire wdt_clear_type clear_in,
   input wire logic [2:0] int_osc_freq_select,
   input wire logic core_asleep,
   output logic low_freq_internal_osc_en,
   output logic timeout_reset,
   output logic timeout_wake,
   output logic [PS_WIDTH-1:0] postscale_count
);
   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   logic [2:0] fsel_reg;
   logic osc_en_reg;
   logic [PS_WIDTH-1:0] ps_reg;
   logic [PS_WIDTH-1:0] ps_next;
   logic rst_reg;
   logic wake_reg;
   logic tick;
   logic fsel_changed;
   logic clr_any;
   logic clr_instr;
   logic clr_fail;
   logic [PS_WIDTH:0] ps_ext;
   logic [PS_WIDTH-1:0] ps_inc;
   logic ps_hold;
   logic sel_bit_next;
   logic sel_bit_now;
   logic sel_hit;
   logic fire;
   logic fire_reset;
   logic fire_wake;

   assign clr_instr = clear_in.sleep_instr || clear_in.clear_watchdog_instr;
   assign fsel_changed = (int_osc_freq_select != fsel_reg);
   assign clr_fail = clear_in.clock_fail;
   assign clr_any = clr_instr || fsel_changed || clr_fail;

   // ----------------------------------------------------------------
   // Base tick
   // ----------------------------------------------------------------
   // Tick counted only while oscillator is on
   wdt_tick_div #(
      .DIV_CYC(TICK_CYC)
   ) u_div (
      .mclk(mclk),
      .nrst(nrst),
      .clr(clr_any),
      .run(osc_en_reg),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // Postscaler and select
   // ----------------------------------------------------------------
   // Ratio 2^sel; sel 15 gives 131.072 s
   assign ps_ext = {1'b0, ps_reg} + {{PS_WIDTH{1'b0}}, 1'b1};
   // Selected output and its next value
   assign sel_bit_next = ps_ext[period_select];
   assign sel_bit_now = ps_reg[period_select];
   assign sel_hit = tick && sel_bit_next && !sel_bit_now;
   assign fire = osc_en_reg && !clr_any && sel_hit;
   assign ps_inc = ps_ext[PS_WIDTH-1:0];
   assign ps_hold = !osc_en_reg || clr_any || fire;
   assign ps_next = ps_hold ? '0 : (tick ? ps_inc : ps_reg);

   // ----------------------------------------------------------------
   // Timeout route
   // ----------------------------------------------------------------
   // Reset while running, wake while asleep
   assign fire_reset = fire && !core_asleep;
   assign fire_wake = fire && core_asleep;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign low_freq_internal_osc_en = osc_en_reg;
   assign timeout_reset = rst_reg;
   assign timeout_wake = wake_reg;
   assign postscale_count = ps_reg;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Enable and select history
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fsel_reg <= WDT_FSEL_RESET;
         osc_en_reg <= 1'b0;
      end else begin
         fsel_reg <= int_osc_freq_select;
         osc_en_reg <= wdt_enable;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ps_reg <= '0;
      end else begin
         ps_reg <= ps_next;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         rst_reg <= fire_reset;
         wake_reg <= fire_wake;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_disabled_zero: assert property (@(posedge mclk) disable iff (!nrst)
      !osc_en_reg |=> (ps_reg == '0))
      else $error("postscaler not zero while disabled");
   a_instr_clear: assert property (@(posedge mclk) disable iff (!nrst)
      (clear_in.sleep_instr || clear_in.clear_watchdog_instr) |=> (ps_reg == '0))
      else $error("instruction clear missed");
   a_fsel_clear: assert property (@(posedge mclk) disable iff (!nrst)
      $changed(int_osc_freq_select) |=> (ps_reg == '0) ##1 !rst_reg && !wake_reg)
      else $error("timeout after frequency change");
   a_fail_clear: assert property (@(posedge mclk) disable iff (!nrst)
      clear_in.clock_fail |=> (ps_reg == '0) && !tick)
      else $error("clock failure clear missed");
   a_osc_follow: assert property (@(posedge mclk) disable iff (!nrst)
      wdt_enable |=> low_freq_internal_osc_en)
      else $error("oscillator not enabled with watchdog");
   a_reset_cause: assert property (@(posedge mclk) disable iff (!nrst)
      rst_reg |-> $past(fire) && !$past(core_asleep))
      else $error("reset without timeout");
   a_wake_cause: assert property (@(posedge mclk) disable iff (!nrst)
      wake_reg |-> $past(fire) && $past(core_asleep))
      else $error("wake without timeout");
   a_ps_step: assert property (@(posedge mclk) disable iff (!nrst)
      (osc_en_reg && !tick && !clr_any) |=> $stable(ps_reg))
      else $error("postscaler moved without tick");
   a_tick_excl: assert property (@(posedge mclk) disable iff (!nrst)
      tick |=> !tick)
      else $error("base tick longer than one cycle");

   // ----------------------------------------------------------------
   // Timeout route checks
   // ----------------------------------------------------------------
   a_reset_single: assert property (@(posedge mclk) disable iff (!nrst)
      rst_reg |=> !rst_reg)
      else $error("timeout reset longer than one cycle");
   a_wake_single: assert property (@(posedge mclk) disable iff (!nrst)
      wake_reg |=> !wake_reg)
      else $error("timeout wake longer than one cycle");
   a_route_excl: assert property (@(posedge mclk) disable iff (!nrst)
      !(rst_reg && wake_reg))
      else $error("reset and wake together");
   a_fire_restart: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_reg || wake_reg) |-> (ps_reg == '0))
      else $error("postscaler not restarted after timeout");
   a_pulse_tick: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_reg || wake_reg) |-> $past(tick))
      else $error("timeout without base tick");
   a_off_silent: assert property (@(posedge mclk) disable iff (!nrst)
      !osc_en_reg |=> !rst_reg && !wake_reg)
      else $error("timeout while disabled");
   a_clear_silent: assert property (@(posedge mclk) disable iff (!nrst)
      clr_any |=> !rst_reg && !wake_reg)
      else $error("timeout despite clear");
   a_sel_zero: assert property (@(posedge mclk) disable iff (!nrst)
      (period_select == '0) && (ps_reg == '0) && tick && osc_en_reg && !clr_any
      |=> (rst_reg || wake_reg))
      else $error("shortest period missed");

   // ----------------------------------------------------------------
   // Clear and count checks
   // ----------------------------------------------------------------
   a_tick_advance: assert property (@(posedge mclk) disable iff (!nrst)
      (osc_en_reg && tick && !clr_any && !fire) |=> ((ps_reg - $past(ps_reg)) == PS_WIDTH'(1)))
      else $error("postscaler did not step on tick");
   a_osc_drop: assert property (@(posedge mclk) disable iff (!nrst)
      !wdt_enable |=> !low_freq_internal_osc_en)
      else $error("oscillator left on while disabled");
   a_tick_gated: assert property (@(posedge mclk) disable iff (!nrst)
      !osc_en_reg |=> !tick)
      else $error("base tick while oscillator off");
   a_tick_clear: assert property (@(posedge mclk) disable iff (!nrst)
      clr_any |=> !tick)
      else $error("base tick right after clear");
   a_enable_zero: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(osc_en_reg) |-> (ps_reg == '0) && !tick)
      else $error("count not zero at enable");
   a_watchdog_clear: assert property (@(posedge mclk) disable iff (!nrst)
      clear_in.clear_watchdog_instr |=> (postscale_count == '0))
      else $error("clear instruction left count");
   a_fsel_count: assert property (@(posedge mclk) disable iff (!nrst)
      fsel_changed |=> (postscale_count == '0))
      else $error("select change left count");
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the watchdog postscaled timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin miscompares++; \
   $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module testbench;
   import wdt_pkg::*;
   localparam int TICK = 4;
   typedef struct {logic wake; int due;} wdt_tb_note_type;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic wdt_enable = 1'b0;
   logic [WDT_SEL_WIDTH-1:0] period_select = 4'h0;
   wdt_clear_type clear_in = 3'h0;
   logic [2:0] int_osc_freq_select = 3'h0;
   logic core_asleep = 1'b0;
   logic low_freq_internal_osc_en;
   logic timeout_reset;
   logic timeout_wake;
   logic [WDT_PS_WIDTH-1:0] postscale_count;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   int period_cyc = 0;
   logic [31:0] lfsr = 32'h014061AA;
   wdt_tb_note_type notes[$];
   wdt_tb_note_type seen_note;

   always #50 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   wdt_top #(.TICK_CYC(TICK)) u_wdt_top (.mclk(mclk), .nrst(nrst), .wdt_enable(wdt_enable),
      .period_select(period_select), .clear_in(clear_in),
      .int_osc_freq_select(int_osc_freq_select), .core_asleep(core_asleep),
      .low_freq_internal_osc_en(low_freq_internal_osc_en), .timeout_reset(timeout_reset),
      .timeout_wake(timeout_wake), .postscale_count(postscale_count));

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #10;
   endtask

   task automatic print_verdict();
      $display("TB: checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Timeout monitor
   // ----------------------------------------------------------------
   always @(negedge mclk) begin
      if (nrst && (timeout_reset | timeout_wake) !== 1'b0) begin
         if (notes.size() == 0) begin
            miscompares++;
            $display("unexpected timeout: expected none seen at cycle %0d", cyc);
         end else begin
            seen_note = notes.pop_front();
            `CHK("timeout_wake", seen_note.wake, timeout_wake)
            `CHK("timeout_reset", !seen_note.wake, timeout_reset)
            `CHK("period", 1'b1, cyc >= seen_note.due - 1 && cyc <= seen_note.due + 4)
         end
      end
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      step(8);
      nrst = 1'b1;
      step(2);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         period_select = 4'(lfsr[2:0] % 5);
         core_asleep = lfsr[8];
         period_cyc = TICK * (1 << period_select);
         wdt_enable = 1'b1;
         notes.push_back('{core_asleep, cyc + period_cyc});
         step(2);
         `CHK("osc_en", 1'b1, low_freq_internal_osc_en)
         step(period_cyc + 2);
         wdt_enable = 1'b0;
         step(2);
         `CHK("osc_en", 1'b0, low_freq_internal_osc_en)
         `CHK("count", 16'h0000, postscale_count)
      end
      period_select = 4'hC;
      core_asleep = 1'b0;
      period_cyc = TICK * (1 << period_select);
      wdt_enable = 1'b1;
      notes.push_back('{core_asleep, cyc + period_cyc});
      step(period_cyc + 4);
      `CHK("pending", 0, notes.size())
      wdt_enable = 1'b0;
      step(2);
      period_select = 4'h2;
      wdt_enable = 1'b1;
      for (int k = 0; k < 4; k++) begin
         step(10);
         `CHK("count", 16'h0002, postscale_count)
         if (k < 3) clear_in = wdt_clear_type'(3'(1 << k));
         else int_osc_freq_select = int_osc_freq_select + 3'h1;
         step(1);
         clear_in = 3'h0;
         step(1);
         `CHK("count", 16'h0000, postscale_count)
      end
      step(6);
      nrst = 1'b0;
      step(2);
      `CHK("count", 16'h0000, postscale_count)
      `CHK("osc_en", 1'b0, low_freq_internal_osc_en)
      nrst = 1'b1;
      step(2);
      `CHK("osc_en", 1'b1, low_freq_internal_osc_en)
      wdt_enable = 1'b0;
      step(4);
      `CHK("pending", 0, notes.size())
      print_verdict();
   end

   initial begin
      #3_000_000;
      miscompares++;
      print_verdict();
   end
endmodule
